// *** rtl/plc_port_pkg.sv ***
package plc_port_pkg;

  // Core clock and the derived host clock.
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned HOST_CLK_HZ  = 4_000_000;
  localparam int unsigned HCLK_HALF    = CLK_HZ / (2 * HOST_CLK_HZ);
  localparam logic [7:0]  HCLK_LAST    = 8'(HCLK_HALF - 1);

  // Power-on quiet time before the host port answers.
  localparam int unsigned POR_TIME_MS  = 10;
  localparam logic [31:0] POR_CYCLES   = 32'(CLK_HZ / 1000 * POR_TIME_MS);

  // Structure sizes in bytes.
  localparam logic [5:0]  CFG_BYTES    = 6'h07;
  localparam logic [5:0]  IFL_BYTES    = 6'h01;
  localparam logic [5:0]  NODE_BYTES   = 6'h02;
  localparam logic [5:0]  STATUS_BYTES = 6'h06;
  localparam logic [5:0]  PKT_BYTES    = 6'h29;
  localparam logic [5:0]  HDR_BYTES    = 6'h08;
  localparam logic [5:0]  RX_MIN_BYTES = 6'h02;

  // Command bytes.
  localparam logic [7:0]  CMD_LM_WRITE   = 8'h01;
  localparam logic [7:0]  CMD_LM_READ    = 8'h02;
  localparam logic [7:0]  CMD_IF_READ    = 8'h03;
  localparam logic [7:0]  CMD_NODE_WRITE = 8'h04;
  localparam logic [7:0]  CMD_STATUS_RD  = 8'h05;
  localparam logic [7:0]  CMD_PKT_TX     = 8'h06;
  localparam logic [7:0]  CMD_PKT_RX     = 8'h07;

  // Interface flag positions and reset value.
  localparam int IF_RA  = 7;
  localparam int IF_TA  = 6;
  localparam int IF_TEX = 5;
  localparam int IF_REX = 4;
  localparam int IF_PLF = 3;
  localparam int IF_IE  = 2;
  localparam int IF_RES = 0;
  localparam logic [7:0] IF_RESET = 8'h01;
  localparam logic [7:0] IF_VALID = 8'hfd;

  // Mode control and node control fields.
  localparam int MC_MR_HI = 6;
  localparam int MC_MR_LO = 3;
  localparam int MC_SL_HI = 1;
  localparam int MC_SL_LO = 0;
  localparam logic [1:0] SL_NODE_MODE = 2'h3;
  localparam int NC_RD_HI = 7;
  localparam int NC_RD_LO = 5;
  localparam int NC_HB    = 3;
  localparam int NC_AT    = 2;
  localparam int NC_ULB   = 1;
  localparam logic [2:0] RD_ACCEPT = 3'h1;

  // Transmit completion codes.
  localparam logic [3:0] TXS_SUCCESS = 4'h0;
  localparam logic [3:0] TXS_EXCESS  = 4'h4;
  localparam logic [3:0] TXS_ABORTED = 4'ha;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] CRC_POLY = 8'h07;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_WAIT = 4'h2,
    TX_DATA = 4'h4,
    TX_CRC  = 4'h8
  } tx_state_t;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_byte

endpackage : plc_port_pkg

// *** rtl/byte_fifo.sv ***
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_t;

  fifo_t            state_r;
  fifo_t            state_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  assign in_ready_o  = (state_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (state_r.cnt != '0);
  assign out_data_o  = mem[state_r.rp];
  assign do_push     = in_valid_i && in_ready_o;
  assign do_pop      = out_ready_i && out_valid_o;

  always_comb
  begin
    state_nxt = state_r;
    if (do_push)
    begin
      state_nxt.wp = (state_r.wp == AW'(DEPTH - 1)) ? '0 : state_r.wp + AW'(1);
    end
    if (do_pop)
    begin
      state_nxt.rp = (state_r.rp == AW'(DEPTH - 1)) ? '0 : state_r.rp + AW'(1);
    end
    state_nxt.cnt = state_r.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (do_push)
    begin
      mem[state_r.wp] <= in_data_i;
    end
  end

  a_fifo_no_overfill: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_r.cnt <= (AW + 1)'(DEPTH)) else $error("fifo count above depth");

endmodule : byte_fifo

// *** rtl/plc_host_port.sv ***
`timescale 1ns/1ps
module plc_host_port
  import plc_port_pkg::*;
#(
  parameter logic [31:0] POR_WAIT    = plc_port_pkg::POR_CYCLES,
  parameter int          SYM_CYCLES  = 16,
  parameter int          BACKOFF     = 64,
  parameter int          FIFO_DEPTH  = 8,
  // Arbitrary identifier value.
  parameter logic [7:0]  DEVICE_ID   = 8'h5a
) (
  // Clock and hardware reset from the host
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Host serial port
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  output logic      attn_n_o,
  // Line side
  output logic      transmit_enable_out_o,
  output logic      sig_out_o,
  output logic      sig_out_oe_o,
  input  wire logic rx_frame_i,
  input  wire logic rx_sym_valid_i,
  input  wire logic rx_sym_i,
  // Clock for the host
  output logic      host_clock_out_o
);
  import plc_port_pkg::*;

  typedef struct packed {
    logic        sclk_q;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  cmd;
    logic        cmd_ok;
    logic [5:0]  byte_idx;
    logic        sdo;
    logic        sdo_oe;
    logic        attn_n;
    logic [7:0]  flags;
    logic [7:0]  mode_ctrl;
    logic [7:0]  node0;
    logic [3:0]  tx_status;
    logic [31:0] por_cnt;
    logic        por_done;
    logic [7:0]  hdiv;
    logic        hclk;
    tx_state_t   txs;
    logic [7:0]  tx_byte;
    logic [2:0]  tx_bit;
    logic [15:0] sym_cnt;
    logic [7:0]  tx_crc;
    logic [7:0]  restarts;
    logic        ts;
    logic        so;
    logic [7:0]  line_sh;
    logic [2:0]  line_bit;
    logic [5:0]  rx_cnt;
    logic [7:0]  rx_crc;
    logic        frame_q;
  } state_t;

  localparam logic [15:0] SYM_LAST = 16'(SYM_CYCLES - 1);
  localparam logic [15:0] BO_LAST  = 16'(BACKOFF - 1);

  state_t     state_r;
  state_t     state_nxt;
  logic [7:0] rx_mem [PKT_BYTES];
  logic       active;
  logic       spi_byte_done;
  logic [7:0] spi_byte;
  logic [7:0] cmd_rd;
  logic [5:0] idx_rd;
  logic [7:0] rd_byte;
  logic [7:0] clr_mask;
  logic [7:0] ev_set;
  logic [7:0] line_byte;
  logic [7:0] restart_limit;
  logic       push;
  logic       pop;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       mem_we;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (spi_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  assign active        = !cs_n_i && state_r.por_done;
  assign spi_byte      = {state_r.rx_sh[6:0], sdi_i};
  assign spi_byte_done = active && sclk_i && !state_r.sclk_q && (state_r.bit_cnt == BIT_LAST);
  assign line_byte     = {state_r.line_sh[6:0], rx_sym_i};
  assign restart_limit = {1'b0, state_r.mode_ctrl[MC_MR_HI:MC_MR_LO], 3'h0};

  always_comb
  begin
    state_nxt = state_r;
    push      = 1'b0;
    pop       = 1'b0;
    mem_we    = 1'b0;
    clr_mask  = 8'h00;
    ev_set    = 8'h00;
    cmd_rd    = state_r.cmd;
    idx_rd    = state_r.byte_idx;
    rd_byte   = 8'h00;

    if (!state_r.por_done)
    begin
      state_nxt.por_cnt  = state_r.por_cnt + 32'h1;
      state_nxt.por_done = (state_r.por_cnt == POR_WAIT - 32'h1);
    end

    // Free running host clock; the divider rounds down to an integer half period.
    if (state_r.hdiv == HCLK_LAST)
    begin
      state_nxt.hdiv = 8'h00;
      state_nxt.hclk = !state_r.hclk;
    end
    else
    begin
      state_nxt.hdiv = state_r.hdiv + 8'h01;
    end

    // Serial slave, mode 0: sample on rising clock, shift out on falling.
    state_nxt.sclk_q = sclk_i;
    state_nxt.sdo_oe = active;
    if (!active)
    begin
      state_nxt.bit_cnt  = 3'h0;
      state_nxt.byte_idx = 6'h00;
      state_nxt.cmd_ok   = 1'b0;
      state_nxt.tx_sh    = 8'h00;
      state_nxt.sdo      = 1'b0;
    end
    else
    begin
      if (sclk_i && !state_r.sclk_q)
      begin
        state_nxt.rx_sh   = spi_byte;
        state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
      end
      else if (!sclk_i && state_r.sclk_q)
      begin
        state_nxt.sdo   = state_r.tx_sh[7];
        state_nxt.tx_sh = {state_r.tx_sh[6:0], 1'b0};
      end
    end

    if (spi_byte_done)
    begin
      if (!state_r.cmd_ok)
      begin
        state_nxt.cmd    = spi_byte;
        state_nxt.cmd_ok = 1'b1;
        cmd_rd           = spi_byte;
        idx_rd           = 6'h00;
        if (spi_byte == CMD_IF_READ)
        begin
          clr_mask = IF_VALID;
        end
        else if ((spi_byte < CMD_LM_WRITE) || (spi_byte > CMD_PKT_RX))
        begin
          ev_set[IF_IE] = 1'b1;
        end
      end
      else
      begin
        state_nxt.byte_idx = state_r.byte_idx + 6'h01;
        idx_rd             = state_r.byte_idx + 6'h01;
        if (state_r.cmd == CMD_LM_WRITE)
        begin
          if (state_r.byte_idx == 6'h00)
          begin
            state_nxt.mode_ctrl   = spi_byte;
            clr_mask[IF_RES]      = 1'b1;
          end
        end
        else if (state_r.cmd == CMD_NODE_WRITE)
        begin
          if (state_r.byte_idx == 6'h00)
          begin
            state_nxt.node0 = spi_byte;
          end
        end
        else if (state_r.cmd == CMD_PKT_TX)
        begin
          // A byte the buffer cannot take is dropped and reported.
          if (fifo_in_ready && (state_r.byte_idx < PKT_BYTES))
          begin
            push = 1'b1;
          end
          else
          begin
            ev_set[IF_IE] = 1'b1;
          end
        end
      end
      if ((cmd_rd == CMD_LM_READ) && (idx_rd == 6'h00))
      begin
        rd_byte = state_r.mode_ctrl;
      end
      else if ((cmd_rd == CMD_IF_READ) && (idx_rd < IFL_BYTES))
      begin
        rd_byte = state_r.flags & IF_VALID;
      end
      else if ((cmd_rd == CMD_STATUS_RD) && (idx_rd == 6'h00))
      begin
        rd_byte = {4'h0, state_r.tx_status};
      end
      else if ((cmd_rd == CMD_STATUS_RD) && (idx_rd == STATUS_BYTES - 6'h01))
      begin
        rd_byte = DEVICE_ID;
      end
      else if ((cmd_rd == CMD_PKT_RX) && (idx_rd < PKT_BYTES))
      begin
        rd_byte = rx_mem[idx_rd];
      end
      state_nxt.tx_sh = rd_byte;
    end

    // Transmit: access the channel, then send each byte as eight symbols.
    case (state_r.txs)
      TX_IDLE:
      begin
        state_nxt.ts = 1'b0;
        state_nxt.so = 1'b0;
        if (!state_r.flags[IF_RES] && fifo_out_valid &&
            (state_r.mode_ctrl[MC_SL_HI:MC_SL_LO] == SL_NODE_MODE))
        begin
          state_nxt.txs      = TX_WAIT;
          state_nxt.restarts = 8'h00;
          state_nxt.sym_cnt  = 16'h0000;
        end
      end
      TX_WAIT:
      begin
        if (state_r.node0[NC_AT])
        begin
          state_nxt.node0[NC_AT] = 1'b0;
          state_nxt.tx_status    = TXS_ABORTED;
          state_nxt.txs          = TX_IDLE;
          ev_set[IF_TA]          = 1'b1;
        end
        else if (rx_frame_i)
        begin
          if (state_r.sym_cnt == BO_LAST)
          begin
            state_nxt.sym_cnt = 16'h0000;
            if (state_r.restarts == restart_limit)
            begin
              state_nxt.tx_status = TXS_EXCESS;
              state_nxt.txs       = TX_IDLE;
              ev_set[IF_TA]       = 1'b1;
            end
            else
            begin
              state_nxt.restarts = state_r.restarts + 8'h01;
            end
          end
          else
          begin
            state_nxt.sym_cnt = state_r.sym_cnt + 16'h0001;
          end
        end
        else
        begin
          pop               = 1'b1;
          state_nxt.tx_byte = fifo_out_data;
          state_nxt.so      = fifo_out_data[7];
          state_nxt.tx_crc  = crc8_byte(8'h00, fifo_out_data);
          state_nxt.tx_bit  = 3'h0;
          state_nxt.sym_cnt = 16'h0000;
          state_nxt.ts      = 1'b1;
          state_nxt.txs     = TX_DATA;
          ev_set[IF_TEX]    = 1'b1;
        end
      end
      TX_DATA, TX_CRC:
      begin
        if (state_r.sym_cnt != SYM_LAST)
        begin
          state_nxt.sym_cnt = state_r.sym_cnt + 16'h0001;
        end
        else
        begin
          state_nxt.sym_cnt = 16'h0000;
          if (state_r.tx_bit != BIT_LAST)
          begin
            state_nxt.tx_byte = {state_r.tx_byte[6:0], 1'b0};
            state_nxt.so      = state_r.tx_byte[6];
            state_nxt.tx_bit  = state_r.tx_bit + 3'h1;
          end
          else if ((state_r.txs == TX_DATA) && fifo_out_valid)
          begin
            pop               = 1'b1;
            state_nxt.tx_byte = fifo_out_data;
            state_nxt.so      = fifo_out_data[7];
            state_nxt.tx_crc  = crc8_byte(state_r.tx_crc, fifo_out_data);
            state_nxt.tx_bit  = 3'h0;
          end
          else if (state_r.txs == TX_DATA)
          begin
            // An empty buffer ends the packet, so the host must keep ahead.
            state_nxt.tx_byte = state_r.tx_crc;
            state_nxt.so      = state_r.tx_crc[7];
            state_nxt.tx_bit  = 3'h0;
            state_nxt.txs     = TX_CRC;
          end
          else
          begin
            state_nxt.ts           = 1'b0;
            state_nxt.so           = 1'b0;
            state_nxt.txs          = TX_IDLE;
            state_nxt.tx_status    = TXS_SUCCESS;
            state_nxt.node0[NC_AT] = 1'b0;
            ev_set[IF_TA]          = 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt.txs = TX_IDLE;
        state_nxt.ts  = 1'b0;
      end
    endcase

    // Receive: frames outside an own transmission are taken without address checks while node0 RD is RD_ACCEPT and no packet is held.
    state_nxt.frame_q = rx_frame_i;
    if (rx_frame_i && !state_r.ts && rx_sym_valid_i)
    begin
      state_nxt.line_sh  = line_byte;
      state_nxt.line_bit = state_r.line_bit + 3'h1;
      if (state_r.line_bit == BIT_LAST)
      begin
        state_nxt.rx_crc = crc8_byte(state_r.rx_crc, line_byte);
        if (state_r.rx_cnt < PKT_BYTES)
        begin
          // A held packet is kept; later frames are refused.
          mem_we           = !state_r.flags[IF_RA];
          state_nxt.rx_cnt = state_r.rx_cnt + 6'h01;
          if (state_r.rx_cnt == HDR_BYTES - 6'h01)
          begin
            ev_set[IF_REX] = 1'b1;
          end
        end
        else
        begin
          ev_set[IF_PLF] = 1'b1;
        end
      end
    end
    if (state_r.frame_q && !rx_frame_i)
    begin
      if ((state_r.rx_cnt >= RX_MIN_BYTES) && (state_r.rx_crc == 8'h00) &&
          (state_r.line_bit == 3'h0) && !state_r.flags[IF_RA] &&
          (state_r.node0[NC_RD_HI:NC_RD_LO] == RD_ACCEPT))
      begin
        ev_set[IF_RA] = 1'b1;
      end
      state_nxt.rx_cnt   = 6'h00;
      state_nxt.rx_crc   = 8'h00;
      state_nxt.line_bit = 3'h0;
    end

    // A flag raised in the cycle of its clear survives.
    state_nxt.flags  = ((state_r.flags & ~clr_mask) | ev_set) & IF_VALID;
    state_nxt.attn_n = !(state_r.por_done && !state_r.node0[NC_HB] &&
                         (|(state_r.flags & {!state_r.node0[NC_ULB], 7'h7f})));
  end

  // The host's hardware reset clears all loaded configuration.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r        <= '0;
      state_r.flags  <= IF_RESET;
      state_r.txs    <= TX_IDLE;
      state_r.attn_n <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (mem_we)
    begin
      rx_mem[state_r.rx_cnt] <= line_byte;
    end
  end

  // Seven output lines; the same flop drives the enable and the output release.
  assign sdo_o                 = state_r.sdo;
  assign sdo_oe_o              = state_r.sdo_oe;
  assign attn_n_o              = state_r.attn_n;
  assign transmit_enable_out_o = state_r.ts;
  assign sig_out_oe_o          = state_r.ts;
  assign sig_out_o             = state_r.so;
  assign host_clock_out_o      = state_r.hclk;

  localparam int A_HALF = HCLK_HALF;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_access_won;
    (state_r.txs == TX_WAIT) ##1 (state_r.txs == TX_DATA);
  endsequence

  a_sdo_release: assert property (cs_n_i |=> !sdo_oe_o)
    else $error("data out driven while deselected");
  a_spi_deselect_idle: assert property (cs_n_i |=> (state_r.bit_cnt == 3'h0) && !state_r.cmd_ok)
    else $error("serial state moved while deselected");
  a_attn_on_flag: assert property ((state_r.por_done && state_r.flags[IF_TA] &&
    !state_r.node0[NC_HB]) |=> !attn_n_o)
    else $error("attention missing for pending flag");
  a_te_while_send: assert property (transmit_enable_out_o |->
    (state_r.txs == TX_DATA) || (state_r.txs == TX_CRC))
    else $error("transmit enable outside a transmission");
  a_so_release: assert property (!transmit_enable_out_o |-> !sig_out_oe_o && !sig_out_o)
    else $error("signal output driven without transmit enable");
  a_hclk_half: assert property ($rose(host_clock_out_o) |-> ##A_HALF $fell(host_clock_out_o))
    else $error("host clock half period wrong");
  a_por_quiet: assert property (!state_r.por_done |=> !sdo_oe_o && state_r.bit_cnt == 3'h0)
    else $error("port active during power-on wait");
  a_flag_read_clear: assert property ((spi_byte_done && !state_r.cmd_ok &&
    spi_byte == CMD_IF_READ && ev_set == 8'h00) |=> state_r.flags == 8'h00)
    else $error("flags not cleared by flag read");
  a_reset_idle: assert property (state_r.flags[IF_RES] |-> state_r.txs == TX_IDLE)
    else $error("transmit started before configuration");
  a_restart_limit: assert property ((state_r.txs == TX_WAIT) |-> state_r.restarts <= restart_limit)
    else $error("restart count above limit");
  a_crc_appended: assert property ($rose(state_r.txs == TX_CRC) |->
    state_r.tx_byte == state_r.tx_crc)
    else $error("trailing byte is not the running crc");
  a_tex_on_access: assert property (s_access_won |-> state_r.flags[IF_TEX] && transmit_enable_out_o)
    else $error("access won without flag and enable");

endmodule : plc_host_port

// *** dv/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic       clock_i,
  // Host serial lines
  output logic            sclk_o     = 1'b0,
  output logic            cs_n_o     = 1'b1,
  output logic            sdi_o      = 1'b0,
  input  wire logic       sdo_i,
  input  wire logic       sdo_oe_i,
  // Byte read back from the data out line
  output logic            got_o      = 1'b0,
  output logic [7:0]      got_byte_o = 8'h00
);
  logic       last_r = 1'b0;
  logic [7:0] sh;

  task automatic select(input logic on);
    @(posedge clock_i);
    cs_n_o <= !on;
    repeat (3) @(posedge clock_i);
  endtask : select

  // Mode 0, MSB first; the clock is held high three core cycles and low four.
  task automatic shift(input logic [7:0] tx, input logic report);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clock_i);
      sdi_o <= tx[i];
      repeat (3) @(posedge clock_i);
      // A released line reads as the inverse of its last bit, so stale data cannot pass.
      sh[i] = sdo_oe_i ? sdo_i : !last_r;
      last_r = sh[i];
      sclk_o <= 1'b1;
      repeat (3) @(posedge clock_i);
      sclk_o <= 1'b0;
    end
    got_byte_o <= sh;
    got_o <= report;
    // The pulse stands for one clock, so the bench sees each byte once.
    @(posedge clock_i);
    got_o <= 1'b0;
  endtask : shift
endmodule : spi_host_model

// *** dv/test_plc_host_port.sv ***
`timescale 1ns/1ps
module test_plc_host_port;
  import plc_port_pkg::*;
  localparam int POR_T = 20;
  localparam int SYM   = 4;
  logic        clock_i  = 1'b0;
  logic        nrst_i   = 1'b0;
  logic        rx_frame = 1'b0;
  logic        rx_sv    = 1'b0;
  logic        rx_sym   = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, attn_n, te, so, so_oe, hclk, got;
  logic [7:0]  got_byte, c, m, p0, p1;
  logic [23:0] fr;
  logic [7:0]  exp_q[$];
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cycles    = 0;
  int          n;

  always #4 clock_i = ~clock_i;

  plc_host_port #(.POR_WAIT(32'h14), .SYM_CYCLES(SYM), .BACKOFF(4)) i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .attn_n_o(attn_n), .transmit_enable_out_o(te),
    .sig_out_o(so), .sig_out_oe_o(so_oe), .rx_frame_i(rx_frame), .rx_sym_valid_i(rx_sv),
    .rx_sym_i(rx_sym), .host_clock_out_o(hclk));
  spi_host_model h (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe), .got_o(got), .got_byte_o(got_byte));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [7:0] crc_of(input logic [15:0] d);
    logic [7:0] k;
    k = 8'h00;
    for (int i = 15; i >= 0; i--)
      k = {k[6:0], 1'b0} ^ ((k[7] ^ d[i]) ? 8'h07 : 8'h00);
    return k;
  endfunction : crc_of

  // Reads note one expected byte per data byte; writes send d0 first, then d1.
  task automatic xact(input logic [7:0] cmd, input int len, input logic [7:0] d0,
                      input logic [7:0] d1, input logic rd);
    h.select(1'b1);
    h.shift(cmd, 1'b0);
    for (int k = 0; k < len; k++)
    begin
      if (rd)
        exp_q.push_back(k == 0 ? d0 : d1);
      h.shift(rd ? 8'h00 : (k == 0 ? d0 : d1), rd);
    end
    h.select(1'b0);
    chk("data out released", 24'h0, 24'(sdo_oe));
  endtask : xact

  task automatic wait_attn();
    n = 0;
    while (attn_n !== 1'b0 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask : wait_attn

  // Counts falling clock edges until the enable shows the given level.
  task automatic te_wait(input logic lvl, input int lim);
    n = 0;
    while (te !== lvl && n < lim)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask : te_wait

  always @(posedge clock_i)
    if (got === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected byte", 24'h0, 24'(got_byte));
      else
        chk("spi byte", 24'(exp_q.pop_front()), 24'(got_byte));
    end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    n = $urandom(60160);
    repeat (4) @(posedge clock_i);
    chk("reset levels", 24'h10, 24'({attn_n, sdo_oe, te, so_oe, hclk}));
    nrst_i <= 1'b1;
    wait_attn();
    chk("power-on wait", 24'h1, 24'(n >= POR_T - 1 && n <= POR_T + 3));
    xact(CMD_IF_READ, 1, IF_RESET, 8'h00, 1'b1);
    xact(CMD_IF_READ, 1, 8'h00, 8'h00, 1'b1);
    chk("attention idle", 24'h1, 24'(attn_n));
    c = 8'($urandom_range(8, 255));
    xact(c, 0, 8'h00, 8'h00, 1'b0);
    chk("attention on error", 24'h0, 24'(attn_n));
    xact(CMD_IF_READ, 1, 8'h04, 8'h00, 1'b1);
    m = {1'b0, 4'($urandom_range(8, 15)), 3'h3};
    p0 = 8'($urandom);
    p1 = 8'($urandom);
    // Before configuration nothing drains the buffer: eight bytes fit, the ninth is refused.
    xact(CMD_PKT_TX, 9, p0, p1, 1'b0);
    xact(CMD_IF_READ, 1, 8'h04, 8'h00, 1'b1);
    rx_frame <= 1'b1;
    xact(CMD_LM_WRITE, 1, m, 8'h00, 1'b0);
    @(posedge clock_i);
    rx_frame <= 1'b0;
    te_wait(1'b1, 20);
    te_wait(1'b0, 400);
    chk("buffered frame length", 24'(9 * 8 * SYM), 24'(n));
    xact(CMD_IF_READ, 1, 8'h60, 8'h00, 1'b1);
    xact(CMD_LM_READ, 7, m, 8'h00, 1'b1);
    // Busy channel holds the frame back until both bytes are queued.
    rx_frame <= 1'b1;
    xact(CMD_PKT_TX, 2, p0, p1, 1'b0);
    chk("held while busy", 24'h0, 24'(te));
    @(posedge clock_i);
    rx_frame <= 1'b0;
    te_wait(1'b1, 20);
    for (int i = 23; i >= 0; i--)
    begin
      @(negedge clock_i);
      fr[i] = so;
      chk("enable pair", 24'h3, 24'({so_oe, te}));
      repeat (3) @(negedge clock_i);
    end
    chk("frame", {p0, p1, crc_of({p0, p1})}, fr);
    repeat (4) @(negedge clock_i);
    chk("released after frame", 24'h0, 24'({te, so_oe}));
    xact(CMD_IF_READ, 1, 8'h60, 8'h00, 1'b1);
    c[0] = hclk;
    while (hclk === c[0])
      @(negedge clock_i);
    n = 0;
    while (hclk !== c[0] && n < 40)
    begin
      @(negedge clock_i);
      n++;
    end
    chk("host clock half period", 24'(HCLK_HALF), 24'(n));
    // Accept received packets, then play a frame with a good check byte onto the line.
    xact(CMD_NODE_WRITE, 1, 8'h20, 8'h00, 1'b0);
    fr = {p0, p1, crc_of({p0, p1})};
    rx_frame <= 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clock_i);
      rx_sv  <= 1'b1;
      rx_sym <= fr[i];
      @(posedge clock_i);
      rx_sv  <= 1'b0;
    end
    @(posedge clock_i);
    rx_frame <= 1'b0;
    wait_attn();
    xact(CMD_IF_READ, 1, 8'h80, 8'h00, 1'b1);
    xact(CMD_PKT_RX, 2, p0, p1, 1'b1);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    wait_attn();
    xact(CMD_LM_READ, 1, 8'h00, 8'h00, 1'b1);
    xact(CMD_IF_READ, 1, IF_RESET, 8'h00, 1'b1);
    repeat (4) @(posedge clock_i);
    chk("all bytes seen", 24'h0, 24'(exp_q.size()));
    conclude();
  end
endmodule : test_plc_host_port
